// ### sbs_pkg.sv
/*
 * sbs_pkg: shared constants, types and state codes for the synchronous
 * pipelined burst memory port.
 * assumes: every file of the block imports this package whole.
 */
`default_nettype none

package sbs_pkg;

   // ----------------------------------------------------------------
   // geometry
   // ----------------------------------------------------------------
   localparam int SBS_ADDR_W = 16;     // 64K locations
   localparam int SBS_DEPTH = 65536;   // words held by the array
   localparam int SBS_BYTES = 4;       // byte lanes per word
   localparam int SBS_BYTE_W = 8;      // bits per lane
   localparam int SBS_DATA_W = 32;     // word width
   localparam int SBS_LOW_W = 2;       // burst counter width

   // ----------------------------------------------------------------
   // constant values
   // ----------------------------------------------------------------
   localparam logic [SBS_BYTES-1:0] SBS_LANES_ALL = 4'hF;
   localparam logic [SBS_BYTES-1:0] SBS_LANES_NONE = 4'h0;
   localparam logic [SBS_LOW_W-1:0] SBS_CNT_RST = 2'h0;
   localparam logic [SBS_LOW_W-1:0] SBS_CNT_ONE = 2'h1;
   localparam logic [SBS_ADDR_W-1:0] SBS_ADDR_RST = 16'h0000;
   localparam logic [SBS_DATA_W-1:0] SBS_DATA_RST = 32'h0000_0000;
   // strap reads high when floating, so interleaved is the safe default
   localparam logic SBS_MODE_RST = 1'h1;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef logic [SBS_DATA_W-1:0] sbs_data_t;

   // synchronous inputs from the processor or cache controller
   typedef struct packed {
      logic [SBS_ADDR_W-1:0] addr;
      logic processor_addr_strobe_n;
      logic controller_addr_strobe_n;
      logic burst_advance_n;
      logic all_bytes_write_n;
      logic byte_write_qualifier_n;
      logic byte_lane3_select_n;
      logic byte_lane2_select_n;
      logic byte_lane1_select_n;
      logic byte_lane0_select_n;
      logic chip_select_first_n;
      logic chip_select_second;
      logic chip_select_third_n;
   } sbs_ctl_t;

   // access state, one-hot
   typedef enum logic [2:0] {
      ST_DESEL = 3'h1,
      ST_READ = 3'h2,
      ST_WRITE = 3'h4
   } sbs_state_t;

endpackage : sbs_pkg

`default_nettype wire

// ### sbs_burst_ctr.sv
/*
 * sbs_burst_ctr: two-bit wrapping burst counter that yields the low
 * address bits of the current and of the following beat.
 * assumes: load and advance come from logic on the same clock; rst_n is
 * an already synchronised active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module sbs_burst_ctr (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic load,
   input wire logic [sbs_pkg::SBS_LOW_W-1:0] low_address_bits,
   input wire logic advance,
   input wire logic interleave,
   output logic [sbs_pkg::SBS_LOW_W-1:0] cur_low_bits,
   output logic [sbs_pkg::SBS_LOW_W-1:0] nxt_low_bits
);
   import sbs_pkg::*;

   logic [SBS_LOW_W-1:0] start_reg; // seed of the burst
   logic [SBS_LOW_W-1:0] start_next;
   logic [SBS_LOW_W-1:0] cnt_reg;   // beats taken so far
   logic [SBS_LOW_W-1:0] cnt_next;

   // ----------------------------------------------------------------
   // beat address from seed and count
   // ----------------------------------------------------------------
   function automatic logic [SBS_LOW_W-1:0] beat_bits(
      input logic [SBS_LOW_W-1:0] seed,
      input logic [SBS_LOW_W-1:0] cnt,
      input logic il
   );
      // interleave or linear
      // the 2-bit sum wraps on its own, which is the wraparound
      beat_bits = il ? (seed ^ cnt) : SBS_LOW_W'(seed + cnt);
   endfunction : beat_bits

   assign cur_low_bits = beat_bits(start_reg, cnt_reg, interleave);
   assign nxt_low_bits = beat_bits(start_reg, SBS_LOW_W'(cnt_reg + SBS_CNT_ONE),
                                   interleave);

   // next counter values
   always_comb begin
      start_next = start_reg;
      cnt_next = cnt_reg;
      if (load) begin
         start_next = low_address_bits;
         cnt_next = SBS_CNT_RST;
      end else if (advance) begin
         cnt_next = SBS_LOW_W'(cnt_reg + SBS_CNT_ONE);
      end
   end

   // counter registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         start_reg <= SBS_CNT_RST;
         cnt_reg <= SBS_CNT_RST;
      end else begin
         start_reg <= start_next;
         cnt_reg <= cnt_next;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_SEED_LOAD: assert property (
      @(posedge clk) disable iff (!rst_n)
      load |=> cur_low_bits == $past(low_address_bits))
      else $error("burst counter did not take the seed");

   AST_LINEAR_STEP: assert property (
      @(posedge clk) disable iff (!rst_n)
      (advance && !load && !interleave) ##1 !interleave
      |-> cur_low_bits == SBS_LOW_W'($past(cur_low_bits) + SBS_CNT_ONE))
      else $error("linear beat did not step by one");

   AST_INTERLEAVE_STEP: assert property (
      @(posedge clk) disable iff (!rst_n)
      (advance && !load && interleave) ##1 interleave
      |-> cur_low_bits == ($past(start_reg) ^ SBS_LOW_W'($past(cnt_reg) + SBS_CNT_ONE)))
      else $error("interleaved beat is not seed xor count");

   AST_HOLD: assert property (
      @(posedge clk) disable iff (!rst_n)
      (!advance && !load) |=> cnt_reg == $past(cnt_reg))
      else $error("burst counter moved without advance");

endmodule : sbs_burst_ctr

`default_nettype wire

// ### sbs_sram_port.sv
/*
 * sbs_sram_port: synchronous pipelined burst memory of 64K words of four
 * bytes, with two address strobes, three chip selects, byte and global
 * writes, a wrapping burst counter and an asynchronous output enable.
 * assumes: the controller runs on clk and drives all synchronous inputs
 * from flops on that clock; the data wire is resolved outside from
 * dq_out and dq_oe; the burst-order strap is static.
 */
//
// Contract
// - address picks one of 64K words
// - capture needs a strobe and selected device
// - low address bits seed burst counter
// - byte lane writes only with qualifier
// - global write stores all four bytes
// - counter steps on advance, else holds
// - selected when first low, second high, third low
// - processor strobe ignored while first select high
// - selects matter only when address loads
// - output enable low drives, high releases
// - first read after deselect stays undriven
// - advance moves burst to next address
// - processor strobe latches address and seed
// - both strobes: processor strobe alone wins
// - controller strobe also latches address, seed
// - counter wraps, four beats per burst
// - strap picks linear low, interleaved high
// - read data one cycle after address
`timescale 1ns/1ps
`default_nettype none

module sbs_sram_port (
   input wire logic clk,
   input wire logic rstn,
   input wire sbs_pkg::sbs_ctl_t ctl,
   input wire logic output_enable_n,
   input wire logic burst_order_strap,
   input wire sbs_pkg::sbs_data_t dq_in,
   output var sbs_pkg::sbs_data_t dq_out,
   output logic dq_oe
);
   import sbs_pkg::*;

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rst_meta_reg; // first stage, read only by the second
   logic rst_n;        // released copy used everywhere else

   // reset asserts at once and leaves on the second edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_reg <= 1'h0;
         rst_n <= 1'h0;
      end else begin
         rst_meta_reg <= 1'h1;
         rst_n <= rst_meta_reg;
      end
   end

   // ----------------------------------------------------------------
   // burst-order strap
   // ----------------------------------------------------------------
   logic strap_s1_reg; // first stage, read only by the second
   logic strap_s2_reg;
   logic strap_s3_reg;
   logic mode_reg;     // 1: interleaved, 0: linear
   logic mode_next;

   // strap change counts once the last two stages agree
   always_comb begin
      mode_next = mode_reg;
      if (strap_s2_reg == strap_s3_reg) begin
         mode_next = strap_s3_reg;
      end
   end

   // strap sampler; the pin is not tied to clk so it is synchronised
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strap_s1_reg <= SBS_MODE_RST;
         strap_s2_reg <= SBS_MODE_RST;
         strap_s3_reg <= SBS_MODE_RST;
         mode_reg <= SBS_MODE_RST;
      end else begin
         strap_s1_reg <= burst_order_strap;
         strap_s2_reg <= strap_s1_reg;
         strap_s3_reg <= strap_s2_reg;
         mode_reg <= mode_next;
      end
   end

   // ----------------------------------------------------------------
   // input decode
   // ----------------------------------------------------------------
   logic sel_ok;                // all three selects active
   logic p_take;                // processor strobe honoured
   logic c_take;                // controller strobe honoured
   logic strobe;                // a new address is offered
   logic [SBS_BYTES-1:0] lanes; // lanes the write inputs ask for

   // write lanes from global write, qualifier and lane selects
   function automatic logic [SBS_BYTES-1:0] write_lanes(input sbs_ctl_t c);
      logic [SBS_BYTES-1:0] sel;
      sel = ~{c.byte_lane3_select_n, c.byte_lane2_select_n,
              c.byte_lane1_select_n, c.byte_lane0_select_n};
      if (!c.all_bytes_write_n) begin
         write_lanes = SBS_LANES_ALL;
      end else if (!c.byte_write_qualifier_n) begin
         write_lanes = sel;
      end else begin
         // unqualified lane selects do nothing
         write_lanes = SBS_LANES_NONE;
      end
   endfunction : write_lanes

   assign sel_ok = !ctl.chip_select_first_n && ctl.chip_select_second &&
                   !ctl.chip_select_third_n;
   assign p_take = !ctl.processor_addr_strobe_n && !ctl.chip_select_first_n;
   assign c_take = !ctl.controller_addr_strobe_n && !p_take;
   assign strobe = p_take || c_take;
   assign lanes = write_lanes(ctl);

   // ----------------------------------------------------------------
   // access sequencing
   // ----------------------------------------------------------------
   sbs_state_t state_reg;
   sbs_state_t state_next;
   logic [SBS_ADDR_W-1:0] addr_reg;  // address of the current beat
   logic [SBS_ADDR_W-1:0] addr_next;
   logic first_reg;                  // access just left deselect
   logic first_next;
   logic [SBS_BYTES-1:0] wr_lanes;   // lanes stored at this edge
   logic load;                       // seed the burst counter
   logic advance;                    // step the burst counter
   logic [SBS_LOW_W-1:0] cur_bits;   // low bits of current beat
   logic [SBS_LOW_W-1:0] nxt_bits;   // low bits of following beat

   // burst counter: seeded on every accepted strobe
   sbs_burst_ctr u_burst (
      .clk(clk),
      .rst_n(rst_n),
      .load(load),
      .low_address_bits(ctl.addr[SBS_LOW_W-1:0]),
      .advance(advance),
      .interleave(mode_reg),
      .cur_low_bits(cur_bits),
      .nxt_low_bits(nxt_bits)
   );

   // next state, address and write lanes
   always_comb begin
      state_next = state_reg;
      addr_next = addr_reg;
      first_next = 1'h0;
      wr_lanes = SBS_LANES_NONE;
      load = 1'h0;
      advance = 1'h0;
      if (strobe) begin
         if (sel_ok) begin
            load = 1'h1;
            addr_next = ctl.addr;
            first_next = (state_reg == ST_DESEL);
            if (p_take) begin
               // write inputs are ignored in a processor-strobe cycle;
               // a write follows on the next edge as a continuation
               state_next = ST_READ;
            end else begin
               wr_lanes = lanes;
               state_next = (lanes != SBS_LANES_NONE) ? ST_WRITE : ST_READ;
            end
         end else begin
            state_next = ST_DESEL;
         end
      end else if (state_reg != ST_DESEL) begin
         advance = !ctl.burst_advance_n;
         addr_next = {addr_reg[SBS_ADDR_W-1:SBS_LOW_W],
                      advance ? nxt_bits : cur_bits};
         wr_lanes = lanes;
         state_next = (lanes != SBS_LANES_NONE) ? ST_WRITE : ST_READ;
      end
   end

   // sequencing registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_DESEL;
         addr_reg <= SBS_ADDR_RST;
         first_reg <= 1'h0;
      end else begin
         state_reg <= state_next;
         addr_reg <= addr_next;
         first_reg <= first_next;
      end
   end

   // ----------------------------------------------------------------
   // storage array
   // ----------------------------------------------------------------
   sbs_data_t mem_arr [SBS_DEPTH]; // no reset: contents are undefined
   sbs_data_t dq_out_next;

   // lane writes; the written word is the one the beat points at
   always_ff @(posedge clk) begin
      for (int i = 0; i < SBS_BYTES; i++) begin
         if (wr_lanes[i]) begin
            mem_arr[addr_next][i*SBS_BYTE_W +: SBS_BYTE_W] <=
               dq_in[i*SBS_BYTE_W +: SBS_BYTE_W];
         end
      end
   end

   // ----------------------------------------------------------------
   // read pipeline and pin drive
   // ----------------------------------------------------------------
   // read-before-write: a write at this edge shows on the next read
   always_comb begin
      dq_out_next = mem_arr[addr_reg];
   end

   // output register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dq_out <= SBS_DATA_RST;
      end else begin
         dq_out <= dq_out_next;
      end
   end

   // pins follow output enable only in read beats
   always_comb begin
      // quiet value first, so an unknown state never drives the pins
      dq_oe = 1'h0;
      unique case (state_reg)
         ST_READ: begin
            dq_oe = !output_enable_n && !first_reg;
         end
         ST_DESEL, ST_WRITE: begin
            // released at once when deselected or taking data
            dq_oe = 1'h0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_all_write;
      c_take && sel_ok && !ctl.all_bytes_write_n;
   endsequence

   sequence s_reread;
      c_take && sel_ok && ctl.all_bytes_write_n && ctl.byte_write_qualifier_n
      && ctl.addr == $past(ctl.addr);
   endsequence

   AST_ADDR_CAPTURE: assert property (
      (strobe && sel_ok) |=> addr_reg == $past(ctl.addr))
      else $error("address not captured on accepted strobe");

   AST_STROBE_PRIORITY: assert property (
      (p_take && !ctl.controller_addr_strobe_n && sel_ok &&
       !ctl.all_bytes_write_n) |=> state_reg == ST_READ)
      else $error("controller strobe acted beside processor strobe");

   AST_FIRST_SELECT_GATE: assert property (
      (ctl.chip_select_first_n && ctl.controller_addr_strobe_n) |=>
      ((state_reg == ST_DESEL) == ($past(state_reg) == ST_DESEL) &&
       addr_reg[SBS_ADDR_W-1:SBS_LOW_W] == $past(addr_reg[SBS_ADDR_W-1:SBS_LOW_W])))
      else $error("access started while first select high");

   AST_DESELECT: assert property (
      (strobe && !sel_ok) |=> (state_reg == ST_DESEL && !dq_oe))
      else $error("unselected strobe did not deselect");

   AST_BURST_KEEPS_SELECT: assert property (
      (!strobe && state_reg != ST_DESEL) |=> state_reg != ST_DESEL)
      else $error("selects acted during burst continuation");

   AST_FIRST_MASK: assert property (
      (state_reg == ST_DESEL && strobe && sel_ok) |=> !dq_oe)
      else $error("pins driven in first beat after deselect");

   AST_OE_HIGH: assert property (
      output_enable_n |-> !dq_oe)
      else $error("pins driven while output enable high");

   AST_ALL_READBACK: assert property (
      s_all_write ##1 s_reread |=> dq_out == $past(dq_in, 2))
      else $error("global write not read back after one cycle");

   AST_LANE_QUAL: assert property (
      (c_take && sel_ok && ctl.all_bytes_write_n &&
       ctl.byte_write_qualifier_n) |-> wr_lanes == SBS_LANES_NONE)
      else $error("lane write without qualifier");

   AST_ADVANCE_ADDR: assert property (
      (!strobe && state_reg != ST_DESEL && !ctl.burst_advance_n)
      |=> addr_reg[SBS_LOW_W-1:0] != $past(addr_reg[SBS_LOW_W-1:0]))
      else $error("advance did not move the burst address");

endmodule : sbs_sram_port

`default_nettype wire

// ### sbs_ctl_model.sv
/*
 * sbs_ctl_model: controller side of the synchronous memory bus, plus the
 * resolved data wire between controller and memory.
 * assumes: the bench calls step from one process, once per clock.
 */
`timescale 1ns/1ps
`default_nettype none

module sbs_ctl_model (
   input wire logic clk,
   output var sbs_pkg::sbs_ctl_t ctl,
   output logic output_enable_n,
   output var sbs_pkg::sbs_data_t dq_in,
   input wire sbs_pkg::sbs_data_t dq_out,
   input wire logic dq_oe
);
   import sbs_pkg::*;

   // ----------------------------------------------------------------
   // data wire
   // ----------------------------------------------------------------
   sbs_data_t wdata_reg; // word the controller offers on the wire
   sbs_data_t last_reg; // wire level seen at the previous edge

   // direction by enable
   // a released wire shows the inverse of its last level, so a memory that
   // writes while nobody drives stores garbage rather than a lucky copy
   assign dq_in = dq_oe ? dq_out : (output_enable_n ? wdata_reg : ~last_reg);

   // remember the wire for the released case
   always @(posedge clk) begin
      last_reg <= dq_in;
   end

   // idle bus at time zero: no strobe, no write
   initial begin
      ctl = '1;
      output_enable_n = 1'b1;
      wdata_reg = '0;
   end

   // ----------------------------------------------------------------
   // one bus cycle
   // ----------------------------------------------------------------
   // address, qualifier and lanes held a full cycle
   task automatic step(input sbs_ctl_t c, input sbs_data_t d, input logic oe_n);
      @(posedge clk);
      ctl <= c;
      wdata_reg <= d;
      output_enable_n <= oe_n;
      // caller sees the effect of the previous step's inputs here
      @(negedge clk);
   endtask : step

endmodule : sbs_ctl_model

`default_nettype wire

// ### testbench.sv
/*
 * testbench: self-checking bench for the burst memory port.
 * assumes: sbs_ctl_model drives the bus; each step returns mid-cycle and
 * shows the outputs caused by the inputs of the step before it.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import sbs_pkg::*;

   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic clk;
   logic rstn;
   logic burst_order_strap;
   sbs_ctl_t ctl;
   logic output_enable_n;
   sbs_data_t dq_in;
   sbs_data_t dq_out;
   logic dq_oe;
   int errors;
   int checks_done;
   int cycles;
   sbs_ctl_t idle; // no strobe, no write, advance high

   // one write row: inputs beside the word that should read back
   typedef struct {
      logic [15:0] addr;
      logic gl_n;
      logic bq_n;
      logic [3:0] lanes_n;
      sbs_data_t d;
      sbs_data_t exp;
   } sbs_row_t;

   sbs_row_t rows [10] = '{
      '{16'h0100, 1'b0, 1'b1, 4'hF, 32'h11111111, 32'h11111111},
      '{16'h0101, 1'b0, 1'b1, 4'hF, 32'h22222222, 32'h22222222},
      '{16'h0102, 1'b0, 1'b1, 4'hF, 32'h33333333, 32'h33333333},
      '{16'h0103, 1'b0, 1'b1, 4'hF, 32'h44444444, 32'h44444444},
      '{16'h0100, 1'b1, 1'b0, 4'hE, 32'hAAAAAAAA, 32'h111111AA},
      '{16'h0101, 1'b1, 1'b0, 4'h6, 32'hBBBBBBBB, 32'hBB2222BB},
      '{16'h0102, 1'b1, 1'b1, 4'h0, 32'hCCCCCCCC, 32'h33333333},
      '{16'h0103, 1'b0, 1'b0, 4'hF, 32'hDDDDDDDD, 32'hDDDDDDDD},
      '{16'hFFFF, 1'b0, 1'b1, 4'hF, 32'h55555555, 32'h55555555},
      '{16'h0000, 1'b0, 1'b1, 4'hF, 32'h66666666, 32'h66666666}};

   // words 0x0100..0x0103 after the rows, burst expectations
   sbs_data_t bw [4] = '{32'h111111AA, 32'hBB2222BB, 32'h33333333, 32'hDDDDDDDD};

   sbs_sram_port u_sbs_sram_port (.clk(clk), .rstn(rstn), .ctl(ctl),
      .output_enable_n(output_enable_n), .burst_order_strap(burst_order_strap),
      .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));

   sbs_ctl_model u_sbs_ctl_model (.clk(clk), .ctl(ctl), .output_enable_n(output_enable_n),
      .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));

   // 25 ns clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // access with all three selects active
   function automatic sbs_ctl_t acc(input logic [15:0] a, input logic p_n, input logic c_n,
         input logic gl_n, input logic bq_n, input logic [3:0] ln, input logic fwd_n);
      return '{a, p_n, c_n, fwd_n, gl_n, bq_n, ln[3], ln[2], ln[1], ln[0], 1'b0, 1'b1, 1'b0};
   endfunction : acc

   task automatic check_data(input sbs_data_t got, input sbs_data_t exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t data %h expected %h", $time, got, exp);
      end
   endtask : check_data

   task automatic check_oe(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t drive enable %b expected %b", $time, got, exp);
      end
   endtask : check_oe

   task automatic st(input sbs_ctl_t c, input sbs_data_t d, input logic oe_n);
      u_sbs_ctl_model.step(c, d, oe_n);
   endtask : st

   // controller-strobe read; data shows one edge after the address edge
   task automatic read_word(input logic [15:0] a, input sbs_data_t exp);
      st(acc(a, 1'b1, 1'b0, 1'b1, 1'b1, 4'hF, 1'b1), '0, 1'b0);
      st(idle, '0, 1'b0);
      st(idle, '0, 1'b0);
      check_data(dq_out, exp);
   endtask : read_word

   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : conclude

   // a hung handshake ends the run as a mismatch
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 1000) begin
         errors++;
         $display("ERROR %0t timeout", $time);
         conclude();
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      sbs_ctl_t c;
      sbs_ctl_t fwd;
      sbs_ctl_t desel;
      logic [1:0] s;
      rstn = 1'b0;
      burst_order_strap = 1'b1;
      errors = 0;
      checks_done = 0;
      cycles = 0;
      idle = acc(16'h0000, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF, 1'b1);
      fwd = idle;
      fwd.burst_advance_n = 1'b0;
      desel = idle;
      desel.controller_addr_strobe_n = 1'b0;
      desel.chip_select_second = 1'b0;
      // reset: outputs quiet, then release and wait for the sync flops
      repeat (11) @(posedge clk);
      @(negedge clk);
      check_oe(dq_oe, 1'b0);
      check_data(dq_out, SBS_DATA_RST);
      @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      // table of single writes, each read back
      foreach (rows[i]) begin
         c = acc(rows[i].addr, 1'b1, 1'b0, rows[i].gl_n, rows[i].bq_n, rows[i].lanes_n, 1'b1);
         st(c, rows[i].d, 1'b1);
         read_word(rows[i].addr, rows[i].exp);
      end
      // each select inactive in turn: write refused, device deselected
      for (int k = 0; k < 3; k++) begin
         c = acc(16'h0000, 1'b1, 1'b0, 1'b0, 1'b1, 4'hF, 1'b1);
         c.chip_select_first_n = (k == 0);
         c.chip_select_second = (k != 1);
         c.chip_select_third_n = (k == 2);
         st(c, 32'hEEEEEEEE, 1'b1);
         st(idle, '0, 1'b0);
         check_oe(dq_oe, 1'b0);
         read_word(16'h0000, 32'h66666666);
      end
      // both strobes: processor strobe wins, its write inputs ignored
      st(acc(16'h0000, 1'b0, 1'b0, 1'b0, 1'b1, 4'hF, 1'b1), 32'h77777777, 1'b1);
      st(idle, '0, 1'b1);
      read_word(16'h0000, 32'h66666666);
      // processor strobe, byte write of lanes 0 and 2 in the next beat
      st(acc(16'hFFFF, 1'b0, 1'b1, 1'b1, 1'b1, 4'hF, 1'b1), '0, 1'b1);
      st(acc(16'h0000, 1'b1, 1'b1, 1'b1, 1'b0, 4'hA, 1'b1), 32'h99999999, 1'b1);
      read_word(16'hFFFF, 32'h55995599);
      // four-beat burst from 0x0102 in each order, plus the wrap beat
      for (int m = 0; m < 2; m++) begin
         @(posedge clk);
         burst_order_strap <= m[0];
         repeat (6) st(idle, '0, 1'b1);
         st(desel, '0, 1'b0);
         st(acc(16'h0102, 1'b1, 1'b0, 1'b1, 1'b1, 4'hF, 1'b1), '0, 1'b0);
         st(fwd, '0, 1'b0);
         check_oe(dq_oe, 1'b0);
         for (int n = 0; n < 5; n++) begin
            st(n < 3 ? fwd : idle, '0, 1'b0);
            s = m[0] ? (2'h2 ^ n[1:0]) : (2'h2 + n[1:0]);
            check_data(dq_out, bw[s]);
            check_oe(dq_oe, 1'b1);
         end
      end
      // processor strobe under first select high changes nothing
      c = acc(16'h0000, 1'b0, 1'b1, 1'b1, 1'b1, 4'hF, 1'b1);
      c.chip_select_first_n = 1'b1;
      st(c, '0, 1'b0);
      c = idle;
      c.chip_select_second = 1'b0;
      st(c, '0, 1'b0);
      check_oe(dq_oe, 1'b1);
      check_data(dq_out, bw[2]);
      // selects without a strobe do not deselect
      st(idle, '0, 1'b0);
      check_oe(dq_oe, 1'b1);
      st(idle, '0, 1'b1);
      check_oe(dq_oe, 1'b0);
      // mid-run reset: drive dropped at once, array contents kept
      st(idle, '0, 1'b0);
      @(posedge clk);
      rstn <= 1'b0;
      @(negedge clk);
      check_oe(dq_oe, 1'b0);
      check_data(dq_out, SBS_DATA_RST);
      @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      read_word(16'h0102, bw[2]);
      conclude();
   end

endmodule : testbench

`default_nettype wire
